//--- hdl/vtce_map.vh
// Register map, field positions and constants of the VLAN tag block
`ifndef VTCE_MAP_VH
`define VTCE_MAP_VH
// Register byte offsets
`define VTCE_PORT_SEL   8'h00
`define VTCE_PORT_CFG   8'h04
`define VTCE_VLAN_SEL   8'h08
`define VTCE_VLAN_MEMB  8'h0C
`define VTCE_STATUS     8'h10
`define VTCE_DROP_CNT   8'h14
`define VTCE_FWD_CNT    8'h18
// PORT_CFG fields
`define VTCE_CFG_VID_HI 11
`define VTCE_CFG_PRI_LO 12
`define VTCE_CFG_PRI_HI 14
`define VTCE_CFG_TAGGED 16
// Reset values, tag and CRC constants
`define VTCE_DEF_VID    12'h001
`define VTCE_NULL_VID   12'h000
`define VTCE_RSV_VID    12'hFFF
`define VTCE_TPID       16'h8100
`define VTCE_CRC_INIT   32'hFFFF_FFFF
`define VTCE_CRC_POLY   32'hEDB8_8320
// Header bytes held before a decision, and emitted lengths
`define VTCE_HDR_LAST   4'hF
`define VTCE_LEN_PLAIN  5'h10
`define VTCE_LEN_INS    5'h14
`define VTCE_LEN_STRIP  5'h0C
`define VTCE_SA_END     5'h0C
`define VTCE_TAG_LEN    5'h04
// AXI responses
`define VTCE_RESP_OKAY  2'b00
`define VTCE_RESP_SLV   2'b10
`endif

//--- hdl/vtce_top.v
// VLAN classification, egress membership filter and tag editor with FIFO
`timescale 1ns/1ps
`default_nettype none
`include "vtce_map.vh"

module vtce_fifo #(
   parameter W  = 9,
   parameter AW = 4
) (
   // Clock and reset
   input  wire         aclk,
   input  wire         aresetn,
   // Fill side
   input  wire [W-1:0] in_data,
   input  wire         in_valid,
   output wire         in_ready,
   // Drain side
   output wire [W-1:0] out_data,
   output wire         out_valid,
   input  wire         out_ready
);
   localparam D = 1 << AW;
   reg  [W-1:0] mem [0:D-1];
   reg  [AW:0]  wp_reg;
   reg  [AW:0]  rp_reg;
   wire         full;
   wire         empty;

   assign full      = (wp_reg[AW] != rp_reg[AW]) &&
                      (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
   assign empty     = (wp_reg == rp_reg);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[rp_reg[AW-1:0]];

   always @(posedge aclk) begin
      if (in_valid && !full) begin
         mem[wp_reg[AW-1:0]] <= in_data;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         wp_reg <= {(AW+1){1'b0}};
         rp_reg <= {(AW+1){1'b0}};
      end else begin
         if (in_valid && !full) begin
            wp_reg <= wp_reg + 1'b1;
         end
         if (out_ready && !empty) begin
            rp_reg <= rp_reg + 1'b1;
         end
      end
   end
endmodule // vtce_fifo

module vtce_top #(
   parameter PW  = 3,
   parameter FAW = 4
) (
   // Clock and reset
   input  wire          aclk,
   input  wire          aresetn,
   // Switched frame in, without FCS
   input  wire [7:0]    in_data,
   input  wire          in_valid,
   input  wire          in_last,
   input  wire [PW-1:0] in_src,
   input  wire [PW-1:0] in_dst,
   output reg           in_ready,
   // Edited frame out, with new FCS
   output wire [7:0]    out_data,
   output wire          out_last,
   output wire          out_valid,
   input  wire          out_ready,
   // AXI4-Lite slave
   input  wire [7:0]    awaddr,
   input  wire          awvalid,
   output wire          awready,
   input  wire [31:0]   wdata,
   input  wire [3:0]    wstrb,
   input  wire          wvalid,
   output wire          wready,
   output wire [1:0]    bresp,
   output wire          bvalid,
   input  wire          bready,
   input  wire [7:0]    araddr,
   input  wire          arvalid,
   output wire          arready,
   output wire [31:0]   rdata,
   output wire [1:0]    rresp,
   output wire          rvalid,
   input  wire          rready
);
   localparam NP = 1 << PW;
   localparam [2:0] S_HDR  = 3'd0;
   localparam [2:0] S_LOOK = 3'd1;
   localparam [2:0] S_CHK  = 3'd2;
   localparam [2:0] S_EMIT = 3'd3;
   localparam [2:0] S_BODY = 3'd4;
   localparam [2:0] S_FCS  = 3'd5;
   localparam [2:0] S_DROP = 3'd6;
   localparam [2:0] S_INIT = 3'd7;

   function [31:0] crc8;
      input [31:0] c;
      input [7:0]  d;
      integer      i;
      reg   [31:0] x;
      begin
         x = c;
         for (i = 0; i < 8; i = i + 1) begin
            x = (x[0] ^ d[i]) ? ((x >> 1) ^ `VTCE_CRC_POLY) : (x >> 1);
         end
         crc8 = x;
      end
   endfunction

   // Configuration and table
   reg  [11:0]   port_default_vlan_id_reg [0:NP-1];
   reg  [2:0]    prio_reg [0:NP-1];
   reg  [NP-1:0] tag_egress_reg;
   reg  [NP-1:0] vmem [0:4095];
   reg  [NP-1:0] vlan1_reg;
   reg  [PW-1:0] psel_reg;
   reg  [11:0]   vsel_reg;
   // Frame path
   reg  [2:0]    state_reg;
   reg  [11:0]   icnt_reg;
   reg  [3:0]    hcnt_reg;
   reg  [127:0]  hdr_reg;
   reg  [PW-1:0] src_reg;
   reg  [PW-1:0] dst_reg;
   reg           hlast_reg;
   reg           tagged_reg;
   reg           bad_reg;
   reg  [11:0]   vid_reg;
   reg  [NP-1:0] memb_reg;
   reg           ins_reg;
   reg           strip_reg;
   reg  [4:0]    eidx_reg;
   reg  [1:0]    fcnt_reg;
   reg  [31:0]   crc_reg;
   reg  [31:0]   drop_cnt_reg;
   reg  [31:0]   fwd_cnt_reg;
   // AXI
   reg  [7:0]    awaddr_reg;
   reg           aw_full_reg;
   reg  [31:0]   wdata_reg;
   reg  [3:0]    wstrb_reg;
   reg           w_full_reg;
   reg           bvalid_reg;
   reg  [1:0]    bresp_reg;
   reg           rvalid_reg;
   reg  [31:0]   rdata_reg;
   reg  [1:0]    rresp_reg;
   reg  [31:0]   rd_next;
   reg           rd_ok;
   reg           wv;
   reg  [7:0]    wd;
   reg           wl;

   wire          init = (state_reg == S_INIT);
   wire [15:0]   tpid = `VTCE_TPID;
   wire          tag_c;
   wire [11:0]   vid_c;
   wire [4:0]    elen;
   wire [4:0]    sidx;
   wire [127:0]  hsh;
   wire [7:0]    emit_byte;
   wire [31:0]   fsh;
   wire          f_rdy;
   wire          wr_do;
   wire          wr_full;
   wire          cfg_we;
   wire          memb_we;
   wire          wr_ok;

   // Classification from the held header
   assign tag_c = (hdr_reg[31:16] == `VTCE_TPID);
   assign vid_c = (tag_c && hdr_reg[11:0] != `VTCE_NULL_VID) ?
                  hdr_reg[11:0] :
                  port_default_vlan_id_reg[src_reg];

   // Header replay, tag spliced in after SA or dropped
   assign elen = ins_reg ? `VTCE_LEN_INS :
                 (strip_reg ? `VTCE_LEN_STRIP : `VTCE_LEN_PLAIN);
   assign sidx = (ins_reg && eidx_reg >= `VTCE_SA_END) ?
                 eidx_reg - `VTCE_TAG_LEN : eidx_reg;
   assign hsh  = hdr_reg << {sidx[3:0], 3'b000};
   assign emit_byte =
      (!ins_reg || eidx_reg < `VTCE_SA_END) ? hsh[127:120] :
      (eidx_reg == 5'd12) ? tpid[15:8] :
      (eidx_reg == 5'd13) ? tpid[7:0] :
      (eidx_reg == 5'd14) ? {prio_reg[src_reg], 1'b0,
                             vid_reg[11:8]} :
      (eidx_reg == 5'd15) ? vid_reg[7:0] : hsh[127:120];
   assign fsh = ~crc_reg >> {fcnt_reg, 3'b000};

   always @* begin
      wv       = 1'b0;
      wd       = 8'h00;
      wl       = 1'b0;
      in_ready = 1'b0;
      case (state_reg)
         S_HDR: in_ready = 1'b1;
         S_EMIT: begin
            wv = 1'b1;
            wd = emit_byte;
         end
         S_BODY: begin
            in_ready = f_rdy;
            wv       = in_valid;
            wd       = in_data;
         end
         S_FCS: begin
            wv = 1'b1;
            wd = fsh[7:0];
            wl = (fcnt_reg == 2'd3);
         end
         S_DROP: in_ready = 1'b1;
         default: in_ready = 1'b0;
      endcase
   end

   vtce_fifo #(.W(9), .AW(FAW)) u_fifo (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_data   ({wl, wd}),
      .in_valid  (wv),
      .in_ready  (f_rdy),
      .out_data  ({out_last, out_data}),
      .out_valid (out_valid),
      .out_ready (out_ready)
   );

   always @(posedge aclk) begin
      if (!aresetn) begin
         state_reg    <= S_INIT;
         icnt_reg     <= 12'h000;
         hcnt_reg     <= 4'h0;
         hdr_reg      <= 128'h0;
         src_reg      <= {PW{1'b0}};
         dst_reg      <= {PW{1'b0}};
         hlast_reg    <= 1'b0;
         tagged_reg   <= 1'b0;
         bad_reg      <= 1'b0;
         vid_reg      <= `VTCE_DEF_VID;
         memb_reg     <= {NP{1'b0}};
         ins_reg      <= 1'b0;
         strip_reg    <= 1'b0;
         eidx_reg     <= 5'h00;
         fcnt_reg     <= 2'd0;
         crc_reg      <= `VTCE_CRC_INIT;
         drop_cnt_reg <= 32'h0000_0000;
         fwd_cnt_reg  <= 32'h0000_0000;
      end else begin
         case (state_reg)
            S_INIT: begin
               icnt_reg <= icnt_reg + 1'b1;
               if (&icnt_reg) begin
                  state_reg <= S_HDR;
               end
            end
            S_HDR: if (in_valid) begin
               hdr_reg <= {hdr_reg[119:0], in_data};
               if (hcnt_reg == 4'h0) begin
                  src_reg <= in_src;
                  dst_reg <= in_dst;
               end
               if (hcnt_reg == `VTCE_HDR_LAST) begin
                  hcnt_reg  <= 4'h0;
                  hlast_reg <= in_last;
                  state_reg <= S_LOOK;
               end else if (in_last) begin
                  hcnt_reg     <= 4'h0;
                  drop_cnt_reg <= drop_cnt_reg + 1'b1;
               end else begin
                  hcnt_reg <= hcnt_reg + 1'b1;
               end
            end
            S_LOOK: begin
               tagged_reg <= tag_c;
               vid_reg    <= vid_c;
               bad_reg    <= (vid_c == `VTCE_RSV_VID);
               memb_reg   <= (vid_c == `VTCE_DEF_VID) ?
                             vlan1_reg : vmem[vid_c];
               state_reg  <= S_CHK;
            end
            S_CHK: begin
               eidx_reg <= 5'h00;
               crc_reg  <= `VTCE_CRC_INIT;
               if (bad_reg || !memb_reg[dst_reg]) begin
                  drop_cnt_reg <= drop_cnt_reg + 1'b1;
                  state_reg    <= hlast_reg ? S_HDR : S_DROP;
               end else begin
                  ins_reg   <= tag_egress_reg[dst_reg] & !tagged_reg;
                  strip_reg <= !tag_egress_reg[dst_reg] & tagged_reg;
                  state_reg <= S_EMIT;
               end
            end
            S_EMIT: if (f_rdy) begin
               crc_reg  <= crc8(crc_reg, emit_byte);
               eidx_reg <= eidx_reg + 1'b1;
               fcnt_reg <= 2'd0;
               if (eidx_reg == elen - 1'b1) begin
                  state_reg <= hlast_reg ? S_FCS : S_BODY;
               end
            end
            S_BODY: if (in_valid && f_rdy) begin
               crc_reg <= crc8(crc_reg, in_data);
               if (in_last) begin
                  state_reg <= S_FCS;
               end
            end
            S_FCS: if (f_rdy) begin
               fcnt_reg <= fcnt_reg + 1'b1;
               if (fcnt_reg == 2'd3) begin
                  fwd_cnt_reg <= fwd_cnt_reg + 1'b1;
                  state_reg   <= S_HDR;
               end
            end
            S_DROP: if (in_valid && in_last) begin
               state_reg <= S_HDR;
            end
            default: state_reg <= S_HDR;
         endcase
      end
   end

   // AXI4-Lite write path
   assign awready = !aw_full_reg;
   assign wready  = !w_full_reg;
   assign bvalid  = bvalid_reg;
   assign bresp   = bresp_reg;
   assign wr_do   = aw_full_reg && w_full_reg && !bvalid_reg && !init;
   assign wr_full = (wstrb_reg == 4'hF);
   assign wr_ok   = (awaddr_reg <= `VTCE_FWD_CNT) &&
                    (awaddr_reg[1:0] == 2'b00);
   assign cfg_we  = wr_do && wr_full && (awaddr_reg == `VTCE_PORT_CFG) &&
                    (wdata_reg[11:0] != `VTCE_NULL_VID) &&
                    (wdata_reg[11:0] != `VTCE_RSV_VID);
   assign memb_we = wr_do && wr_full && (awaddr_reg == `VTCE_VLAN_MEMB);

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= 1'b0;
         w_full_reg  <= 1'b0;
         awaddr_reg  <= 8'h00;
         wdata_reg   <= 32'h0000_0000;
         wstrb_reg   <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `VTCE_RESP_OKAY;
         psel_reg    <= {PW{1'b0}};
         vsel_reg    <= `VTCE_DEF_VID;
         vlan1_reg   <= {NP{1'b1}};
      end else begin
         if (awvalid && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            awaddr_reg  <= awaddr;
         end
         if (wvalid && !w_full_reg) begin
            w_full_reg <= 1'b1;
            wdata_reg  <= wdata;
            wstrb_reg  <= wstrb;
         end
         if (wr_do) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= wr_ok ? `VTCE_RESP_OKAY : `VTCE_RESP_SLV;
            if (wr_full && awaddr_reg == `VTCE_PORT_SEL) begin
               psel_reg <= wdata_reg[PW-1:0];
            end
            if (wr_full && awaddr_reg == `VTCE_VLAN_SEL) begin
               vsel_reg <= wdata_reg[11:0];
            end
         end else if (bvalid_reg && bready) begin
            bvalid_reg <= 1'b0;
         end
         if (memb_we) begin
            if (vsel_reg == `VTCE_DEF_VID) begin
               vlan1_reg <= wdata_reg[NP-1:0];
            end else begin
               vlan1_reg <= vlan1_reg & ~wdata_reg[NP-1:0];
            end
         end
      end
   end

   // Table: cleared by the sweep after reset, then written by software
   always @(posedge aclk) begin
      if (init) begin
         vmem[icnt_reg] <= {NP{1'b0}};
      end else if (memb_we && vsel_reg != `VTCE_DEF_VID) begin
         vmem[vsel_reg] <= wdata_reg[NP-1:0];
      end
   end

   // Per-port default VLAN, priority and egress mode
   genvar g;
   generate
      for (g = 0; g < NP; g = g + 1) begin : g_port
         localparam [PW-1:0] PI = g;
         always @(posedge aclk) begin
            if (!aresetn) begin
               port_default_vlan_id_reg[g] <= `VTCE_DEF_VID;
               prio_reg[g]                 <= 3'd0;
               tag_egress_reg[g]           <= 1'b0;
            end else if (cfg_we && psel_reg == PI) begin
               port_default_vlan_id_reg[g] <= wdata_reg[11:0];
               prio_reg[g] <= wdata_reg[`VTCE_CFG_PRI_HI:`VTCE_CFG_PRI_LO];
               tag_egress_reg[g] <= wdata_reg[`VTCE_CFG_TAGGED];
            end
         end
      end
   endgenerate

   // AXI4-Lite read path
   assign arready = !rvalid_reg;
   assign rvalid  = rvalid_reg;
   assign rdata   = rdata_reg;
   assign rresp   = rresp_reg;

   always @* begin
      rd_next = 32'h0000_0000;
      rd_ok   = 1'b1;
      case (araddr)
         `VTCE_PORT_SEL: rd_next[PW-1:0] = psel_reg;
         `VTCE_PORT_CFG: begin
            rd_next[`VTCE_CFG_VID_HI:0] = port_default_vlan_id_reg[psel_reg];
            rd_next[`VTCE_CFG_PRI_HI:`VTCE_CFG_PRI_LO] = prio_reg[psel_reg];
            rd_next[`VTCE_CFG_TAGGED] = tag_egress_reg[psel_reg];
         end
         `VTCE_VLAN_SEL: rd_next[11:0] = vsel_reg;
         `VTCE_VLAN_MEMB: rd_next[NP-1:0] = (vsel_reg == `VTCE_DEF_VID) ?
                                            vlan1_reg : vmem[vsel_reg];
         `VTCE_STATUS: rd_next[1:0] = {state_reg != S_HDR, init};
         `VTCE_DROP_CNT: rd_next = drop_cnt_reg;
         `VTCE_FWD_CNT: rd_next = fwd_cnt_reg;
         default: rd_ok = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= `VTCE_RESP_OKAY;
      end else if (arvalid && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_next;
         rresp_reg  <= rd_ok ? `VTCE_RESP_OKAY : `VTCE_RESP_SLV;
      end else if (rvalid_reg && rready) begin
         rvalid_reg <= 1'b0;
      end
   end
endmodule // vtce_top

`default_nettype wire

//--- verification/vtce_sink.sv
// Receiving station model that drains the edited stream
`timescale 1ns/1ps
`default_nettype none

module vtce_sink (
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Edited stream
   input  wire logic [7:0] out_data,
   input  wire logic       out_last,
   input  wire logic       out_valid,
   output var  logic       out_ready,
   // Back-pressure request
   input  wire logic       stall
);
   logic [7:0] got[$];
   int         frames = 0;
   int         held = 0;

   // Plain tag-unaware station; long stall fills the FIFO, then half rate
   always @(posedge aclk) begin
      if (!aresetn) begin
         out_ready <= 1'b0;
         held      <= 0;
      end else begin
         held      <= stall ? held + 1 : 0;
         out_ready <= stall ? (held > 40 && !out_ready) : 1'b1;
         if (out_valid && out_ready) begin
            got.push_back(out_data);
            if (out_last) begin
               frames <= frames + 1;
            end
         end
      end
   end
endmodule // vtce_sink

`default_nettype wire

//--- verification/vtce_top_checker.sv
// Port-level assertions for the VLAN tag block
`timescale 1ns/1ps
`default_nettype none

module vtce_top_checker (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Frame in and out
   input wire logic        in_valid,
   input wire logic        in_last,
   input wire logic        in_ready,
   input wire logic [7:0]  out_data,
   input wire logic        out_last,
   input wire logic        out_valid,
   input wire logic        out_ready,
   // Register bus
   input wire logic [7:0]  araddr,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready
);
   logic [12:0] sweep_cnt;
   logic [4:0]  in_cnt;
   logic [5:0]  out_cnt;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Cycles since reset, bytes into and out of the current frame
   always @(posedge aclk) begin
      if (!aresetn) begin
         sweep_cnt <= 13'h0000;
         in_cnt    <= 5'h00;
         out_cnt   <= 6'h00;
      end else begin
         if (sweep_cnt != 13'h1000)
            sweep_cnt <= sweep_cnt + 13'h0001;
         if (in_valid && in_ready)
            in_cnt <= in_last ? 5'h00 :
                      (in_cnt == 5'h10 ? in_cnt : in_cnt + 5'h01);
         if (out_valid && out_ready)
            out_cnt <= out_last ? 6'h00 :
                       (out_cnt == 6'h3F ? out_cnt : out_cnt + 6'h01);
      end
   end

   sequence s_hdr_taken;
      in_valid && in_ready && in_cnt == 5'h0F && !in_last;
   endsequence
   sequence s_decide;
      !in_ready [*2];
   endsequence

   a_hdr_wait: assert property (s_hdr_taken |=> s_decide)
      else $error("input taken during header decision");
   a_sweep_block: assert property (sweep_cnt < 13'h1000 |-> !in_ready)
      else $error("frame taken during table sweep");
   a_reset_quiet: assert property ($rose(aresetn) |->
      !out_valid && !bvalid && !rvalid)
      else $error("output valid right after reset");
   a_fcs_len: assert property (out_valid && out_ready && out_last |->
      out_cnt >= 6'h0F)
      else $error("frame ended too short for header and check sequence");
   a_out_hold: assert property (out_valid && !out_ready |=>
      out_valid && $stable(out_data) && $stable(out_last))
      else $error("stream byte changed while stalled");
   a_rd_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   a_rd_unmapped: assert property (arvalid && arready && araddr > 8'h18 |=>
      rresp == 2'b10 && rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   a_r_hold: assert property (rvalid && !rready |=>
      rvalid && $stable(rdata) && $stable(rresp))
      else $error("read answer changed before taken");
   a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer changed before taken");
endmodule // vtce_top_checker

bind vtce_top vtce_top_checker i_vtce_top_checker (
   .aclk(aclk), .aresetn(aresetn), .in_valid(in_valid), .in_last(in_last),
   .in_ready(in_ready), .out_data(out_data), .out_last(out_last),
   .out_valid(out_valid), .out_ready(out_ready), .araddr(araddr),
   .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
   .rvalid(rvalid), .rready(rready), .bresp(bresp), .bvalid(bvalid),
   .bready(bready)
);

`default_nettype wire

//--- verification/vtce_top_tb.sv
// Self-checking bench for the VLAN tag block
`timescale 1ns/1ps
`default_nettype none

module vtce_top_tb;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  in_data = 8'h00;
   logic        in_valid = 1'b0;
   logic        in_last = 1'b0;
   logic [2:0]  in_src = 3'h0;
   logic [2:0]  in_dst = 3'h0;
   logic        in_ready;
   logic [7:0]  out_data;
   logic        out_last;
   logic        out_valid;
   logic        out_ready;
   logic        stall = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        awready;
   logic        wready;
   logic        bvalid;
   logic        arready;
   logic        rvalid;
   logic [1:0]  bresp;
   logic [1:0]  rresp;
   logic [31:0] rdata;
   logic [7:0]  fq[$];
   logic [7:0]  xq[$];
   int          err_total = 0;
   int          checks = 0;

   always #12.5 aclk = ~aclk;

   vtce_top i_vtce_top (
      .aclk(aclk), .aresetn(aresetn), .in_data(in_data),
      .in_valid(in_valid), .in_last(in_last), .in_src(in_src),
      .in_dst(in_dst), .in_ready(in_ready), .out_data(out_data),
      .out_last(out_last), .out_valid(out_valid), .out_ready(out_ready),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready)
   );
   vtce_sink i_vtce_sink (
      .aclk(aclk), .aresetn(aresetn), .out_data(out_data),
      .out_last(out_last), .out_valid(out_valid), .out_ready(out_ready),
      .stall(stall)
   );

   task automatic test_done;
      if (err_total == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic cmp(input string n, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (awvalid || wvalid);
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      cmp("write resp", (a > 8'h18 || a[1:0] != 2'b00) ? 2 : 0, bresp);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (arvalid);
      rready <= 1'b1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic chk(input string n, input logic [7:0] a,
                      input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      cmp(n, e, d);
      cmp("read resp", 32'h0000_0000, r);
   endtask

   function automatic logic [31:0] crc(input logic [7:0] q[$]);
      logic [31:0] c;
      c = 32'hFFFF_FFFF;
      foreach (q[i]) begin
         c = c ^ {24'h00_0000, q[i]};
         for (int k = 0; k < 8; k++)
            c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
      end
      return ~c;
   endfunction

   // Addresses, optional tag word pair, type and payload
   task automatic mk(input logic [15:0] tp, tci);
      fq.delete();
      for (int i = 0; i < 12; i++) fq.push_back(8'h10 + 8'(i));
      if (tp != 16'h0000) fq = {fq, tp[15:8], tp[7:0], tci[15:8], tci[7:0]};
      fq = {fq, 8'h08, 8'h00};
      for (int i = 0; i < 6; i++) fq.push_back(8'hA0 + 8'(i));
   endtask

   task automatic send(input logic [2:0] s, t);
      for (int i = 0; i < fq.size(); i++) begin
         in_valid <= 1'b1;
         in_data <= fq[i];
         in_last <= (i == fq.size() - 1);
         in_src <= s;
         in_dst <= t;
         do @(posedge aclk); while (in_ready !== 1'b1);
      end
      in_valid <= 1'b0;
      in_last <= 1'b0;
   endtask

   // Modes: 0 keep, 1 insert tag, 2 strip tag, 3 dropped
   task automatic frame(input logic [2:0] s, t, input int mode,
                        input logic [15:0] tci, input logic st);
      logic [31:0] c;
      int          n;
      int          f0;
      stall <= st;
      i_vtce_sink.got.delete();
      f0 = i_vtce_sink.frames;
      send(s, t);
      n = 0;
      while (n < 300 && (mode == 3 || i_vtce_sink.frames == f0)) begin
         @(posedge aclk);
         n++;
      end
      xq = fq;
      if (mode == 1)
         xq = {fq[0:11], 8'h81, 8'h00, tci[15:8], tci[7:0], fq[12:$]};
      if (mode == 2)
         xq = {fq[0:11], fq[16:$]};
      c = crc(xq);
      for (int k = 0; k < 4; k++) xq.push_back(c[8*k +: 8]);
      if (mode == 3)
         xq.delete();
      cmp("frame length", xq.size(), i_vtce_sink.got.size());
      foreach (xq[i]) cmp("frame byte", xq[i], i_vtce_sink.got[i]);
   endtask

   initial begin
      repeat (30000) @(posedge aclk);
      err_total++;
      test_done;
   end

   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      do rd(8'h10, d, r); while (d[0] !== 1'b0);
      for (int p = 0; p < 8; p++) begin
         wr(8'h00, p);
         chk("port cfg", 8'h04, 32'h0000_0001);
      end
      wr(8'h08, 32'h0000_0001);
      chk("vlan1 members", 8'h0C, 32'h0000_00FF);
      wr(8'h08, 32'h0000_0002);
      chk("vlan2 members", 8'h0C, 32'h0000_0000);
      rd(8'h1C, d, r);
      cmp("unmapped resp", 32'h0000_0002, r);
      cmp("unmapped data", 32'h0000_0000, d);
      mk(16'h0000, 16'h0000);
      frame(0, 5, 0, 16'h0000, 0);
      wr(8'h08, 32'h0000_000A);
      wr(8'h0C, 32'h0000_000E);
      wr(8'h08, 32'h0000_0001);
      chk("vlan1 after add", 8'h0C, 32'h0000_00F1);
      wr(8'h00, 32'h0000_0001);
      wr(8'h04, 32'h0000_500A);
      chk("port1 cfg", 8'h04, 32'h0000_500A);
      wr(8'h00, 32'h0000_0002);
      wr(8'h04, 32'h0001_000A);
      frame(1, 2, 1, 16'hA00A, 1);
      frame(1, 0, 3, 16'h0000, 0);
      mk(16'h8100, 16'h600A);
      frame(0, 3, 2, 16'h0000, 0);
      frame(0, 2, 0, 16'h0000, 1);
      frame(0, 4, 3, 16'h0000, 0);
      chk("drop count", 8'h14, 32'h0000_0002);
      mk(16'h8101, 16'h600A);
      frame(1, 2, 1, 16'hA00A, 0);
      wr(8'h08, 32'h0000_0FFE);
      wr(8'h0C, 32'h0000_0010);
      mk(16'h8100, 16'h0FFE);
      frame(0, 4, 2, 16'h0000, 1);
      wr(8'h00, 32'h0000_0001);
      wr(8'h04, 32'h0000_0FFF);
      chk("port1 cfg kept", 8'h04, 32'h0000_500A);
      wr(8'h1C, 32'h0000_0001);
      chk("fwd count", 8'h18, 32'h0000_0006);
      chk("drop count end", 8'h14, 32'h0000_0002);
      chk("status idle", 8'h10, 32'h0000_0000);
      test_done;
   end
endmodule // vtce_top_tb

`default_nettype wire
